// >>> rtl/rcocc_ctrl.sv
// Purpose: gate-and-count control of an rc oscillation converter
// Assumes: ref_clk 100 MHz; rcOscClock is asynchronous and slower than ref_clk / 4
// Notes: converterControl0 written by ctrlWrite; counters preset through load strobes
`default_nettype none
module rcocc_ctrl
    import rcocc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ctrlWrite,
    input wire logic [1:0] ctrlWriteData,
    input wire logic oscModeWrite,
    input wire logic [MODE_WIDTH-1:0] oscModeWriteData,
    input wire logic decadeLoad,
    input wire logic [DEC_WIDTH-1:0] decadeLoadData,
    input wire logic binaryLoad,
    input wire logic [BIN_WIDTH-1:0] binaryLoadData,
    input wire logic rcOscClock,
    output logic conversionEnable,
    output logic counterRefSelect,
    output logic countRun,
    output logic converterIrq,
    output logic [MODE_WIDTH-1:0] oscModeField,
    output logic [6:0] oscPathEnable,
    output rcocc_counts_type counts
);

    ////////////////////////////////////////////////////////////////////
    // bcd increment; carry out marks overflow past 79999
    // top digit wraps at 7, the lower digits at 9
    function automatic logic [DEC_WIDTH:0] decInc(input logic [DEC_WIDTH-1:0] v);
        logic [DEC_WIDTH-1:0] r;
        logic c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < DEC_DIGITS; i++) begin
            if (c) begin
                if (r[4*i +: 4] == ((i == DEC_DIGITS - 1) ? DEC_TOP_DIGIT_MAX : DEC_DIGIT_MAX)) begin
                    r[4*i +: 4] = 4'h0;
                end else begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return {c, r};
    endfunction

    ////////////////////////////////////////////////////////////////////
    // oscillator clock synchroniser and rising-edge detect
    // only oscSync_q reads the first stage
    logic oscMeta_q, oscSync_q, oscPrev_q;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            oscMeta_q <= 1'b0;
            oscSync_q <= 1'b0;
            oscPrev_q <= 1'b0;
        end else begin
            oscMeta_q <= rcOscClock;
            oscSync_q <= oscMeta_q;
            oscPrev_q <= oscSync_q;
        end
    end
    logic oscEdge;
    assign oscEdge = oscSync_q & ~oscPrev_q;

    ////////////////////////////////////////////////////////////////////
    // run signal taken on the falling system clock edge
    // half-cycle lead lets the arm state see run one edge after enable
    logic enable_q, enable_d, refSel_q, refSel_d, run_q;
    always_ff @(negedge ref_clk or posedge reset) begin
        if (reset) begin
            run_q <= 1'b0;
        end else begin
            run_q <= enable_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control, counters and state
    rcocc_state_type state_q, state_d;
    logic [DEC_WIDTH-1:0] dec_q, dec_d;
    logic [BIN_WIDTH-1:0] bin_q, bin_d;
    logic [MODE_WIDTH-1:0] mode_q, mode_d;
    logic irq_q, irq_d, runOut_q, runOut_d;
    logic [6:0] path_q, path_d;
    logic [DEC_WIDTH:0] decNext;
    logic decGateEnd, binGateEnd;

    ////////////////////////////////////////////////////////////////////
    // gate end: overflow of whichever counter is the time reference
    assign decNext = decInc(dec_q);
    assign decGateEnd = !refSel_q && decNext[DEC_WIDTH];
    assign binGateEnd = refSel_q && oscEdge && (bin_q == BIN_MAX);

    always_comb begin
        enable_d = enable_q;
        refSel_d = refSel_q;
        state_d = state_q;
        dec_d = dec_q;
        bin_d = bin_q;
        mode_d = mode_q;
        irq_d = 1'b0;
        if (ctrlWrite) begin
            enable_d = ctrlWriteData[CTRL_ENABLE_BIT];
            refSel_d = ctrlWriteData[CTRL_REFSEL_BIT];
        end
        if (oscModeWrite) begin
            mode_d = oscModeWriteData;
        end
        if (decadeLoad) begin
            dec_d = decadeLoadData;
        end
        if (binaryLoad) begin
            bin_d = binaryLoadData;
        end
        case (state_q)
            RCOCC_IDLE: begin
                if (enable_q) begin
                    state_d = RCOCC_ARM;
                end
            end
            RCOCC_ARM: begin
                if (!enable_q) begin
                    state_d = RCOCC_IDLE;
                end else if (run_q) begin
                    state_d = RCOCC_COUNT;
                end
            end
            RCOCC_COUNT: begin
                // software writing enable 0 aborts with no interrupt
                if (!enable_q) begin
                    state_d = RCOCC_IDLE;
                end else begin
                    dec_d = decNext[DEC_WIDTH-1:0];
                    if (oscEdge) begin
                        bin_d = bin_q + 14'h0001;
                    end
                    // evaluated after the write above, so an overflow clear wins
                    if (decGateEnd) begin
                        enable_d = 1'b0;
                        irq_d = 1'b1;
                        state_d = RCOCC_IDLE;
                    end else if (binGateEnd) begin
                        enable_d = 1'b0;
                        irq_d = 1'b1;
                        state_d = RCOCC_IDLE;
                    end
                end
            end
            default: begin
                state_d = RCOCC_IDLE;
            end
        endcase
        runOut_d = (state_d == RCOCC_COUNT);
        // modes 0, 7 and above drive no oscillator path
        path_d = 7'h00;
        if (enable_d && mode_d != OSC_MODE_OFF && mode_d <= OSC_MODE_LAST) begin
            path_d[mode_d[2:0]] = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            enable_q <= 1'b0;
            refSel_q <= 1'b0;
            state_q <= RCOCC_IDLE;
            dec_q <= '0;
            bin_q <= '0;
            mode_q <= OSC_MODE_OFF;
            irq_q <= 1'b0;
            runOut_q <= 1'b0;
            path_q <= 7'h00;
        end else begin
            enable_q <= enable_d;
            refSel_q <= refSel_d;
            state_q <= state_d;
            dec_q <= dec_d;
            bin_q <= bin_d;
            mode_q <= mode_d;
            irq_q <= irq_d;
            runOut_q <= runOut_d;
            path_q <= path_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // every output comes straight from a register
    assign conversionEnable = enable_q;
    assign counterRefSelect = refSel_q;
    assign countRun = runOut_q;
    assign converterIrq = irq_q;
    assign oscModeField = mode_q;
    assign oscPathEnable = path_q;
    assign counts.decadeValue = dec_q;
    assign counts.binaryValue = bin_q;

endmodule // rcocc_ctrl
`default_nettype wire

// >>> rtl/rcocc_pkg.sv
// Purpose: shared constants and types for the rc oscillator ratio counter control
// Assumes: one system clock domain; oscillator clock arrives as a plain input
// Notes: counters are loaded and read over plain ports
`default_nettype none
package rcocc_pkg;
    localparam int DEC_DIGITS = 5;
    localparam int DEC_WIDTH = 4 * DEC_DIGITS;
    localparam int BIN_WIDTH = 14;
    localparam int MODE_WIDTH = 4;
    localparam logic [3:0] DEC_TOP_DIGIT_MAX = 4'h7;
    localparam logic [3:0] DEC_DIGIT_MAX = 4'h9;
    localparam logic [BIN_WIDTH-1:0] BIN_MAX = 14'h3FFF;
    localparam logic [MODE_WIDTH-1:0] OSC_MODE_OFF = 4'h0;
    localparam logic [MODE_WIDTH-1:0] OSC_MODE_LAST = 4'h6;
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_REFSEL_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;

    typedef enum logic [1:0] {
        RCOCC_IDLE = 2'b00,
        RCOCC_ARM = 2'b01,
        RCOCC_COUNT = 2'b10
    } rcocc_state_type;

    typedef struct packed {
        logic [DEC_WIDTH-1:0] decadeValue;
        logic [BIN_WIDTH-1:0] binaryValue;
    } rcocc_counts_type;
endpackage
`default_nettype wire

// >>> testbench/rcocc_osc_model.sv
// Purpose: oscillator stand-in for the rc oscillation paths
// Assumes: 160 ns period while any path is enabled
// Notes: output stands low while no path is enabled
`default_nettype none
module rcocc_osc_model (
    input wire logic [6:0] pathEnable,
    output logic rc_osc_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        rc_osc_clock = 1'b0;
        #3;
        forever #80 rc_osc_clock = (|pathEnable) ? ~rc_osc_clock : 1'b0;
    end
endmodule // rcocc_osc_model
`default_nettype wire

// >>> testbench/rcocc_ctrl_chk.sv
// Purpose: port checker for rcocc_ctrl
// Assumes: one clock domain, async active-high reset
// Notes: bound to every rcocc_ctrl instance
`default_nettype none
module rcocc_ctrl_chk
    import rcocc_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic ctrlWrite,
    input wire logic decadeLoad,
    input wire logic binaryLoad,
    input wire logic conversionEnable,
    input wire logic counterRefSelect,
    input wire logic countRun,
    input wire logic converterIrq,
    input wire logic [6:0] oscPathEnable,
    input wire rcocc_counts_type counts
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    property p_irqClr;
        converterIrq |-> !conversionEnable;
    endproperty
    a_irqClr: assert property (p_irqClr) else $error("irq with enable set");
    property p_irqOne;
        converterIrq |=> !converterIrq;
    endproperty
    a_irqOne: assert property (p_irqOne) else $error("irq longer than one cycle");
    property p_decWrap;
        converterIrq && !counterRefSelect |-> counts.decadeValue == 20'h0;
    endproperty
    a_decWrap: assert property (p_decWrap) else $error("decade end value");
    property p_binWrap;
        converterIrq && counterRefSelect |-> counts.binaryValue == 14'h0;
    endproperty
    a_binWrap: assert property (p_binWrap) else $error("binary end value");
    property p_idle;
        !conversionEnable && !ctrlWrite |=> oscPathEnable == 7'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("path on while idle");
    property p_oneHot;
        $onehot0(oscPathEnable);
    endproperty
    a_oneHot: assert property (p_oneHot) else $error("two paths on");
    property p_start;
        $rose(conversionEnable) |-> ##[1:4] countRun;
    endproperty
    a_start: assert property (p_start) else $error("run late");
    property p_hold;
        !conversionEnable && !$past(conversionEnable) && !$past(decadeLoad)
            && !$past(binaryLoad) |-> $stable(counts);
    endproperty
    a_hold: assert property (p_hold) else $error("counts moved while idle");
endmodule // rcocc_ctrl_chk
bind rcocc_ctrl rcocc_ctrl_chk rcocc_ctrl_chk_i (
    .ref_clk(ref_clk),
    .reset(reset),
    .ctrlWrite(ctrlWrite),
    .decadeLoad(decadeLoad),
    .binaryLoad(binaryLoad),
    .conversionEnable(conversionEnable),
    .counterRefSelect(counterRefSelect),
    .countRun(countRun),
    .converterIrq(converterIrq),
    .oscPathEnable(oscPathEnable),
    .counts(counts)
);
`default_nettype wire

// >>> testbench/rcocc_ctrl_tb.sv
// Purpose: directed bench for rcocc_ctrl
// Assumes: oscillator model period 160 ns, ref_clk 10 ns
// Notes: short gates keep the run brief
`default_nettype none
module rcocc_ctrl_tb
    import rcocc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk, reset, ctrlWrite, oscModeWrite, decadeLoad, binaryLoad;
    logic [1:0] ctrlWriteData;
    logic [MODE_WIDTH-1:0] oscModeWriteData, oscModeField;
    logic [DEC_WIDTH-1:0] decadeLoadData;
    logic [BIN_WIDTH-1:0] binaryLoadData;
    logic rcOscClock, conversionEnable, counterRefSelect, countRun, converterIrq;
    logic [6:0] oscPathEnable;
    rcocc_counts_type counts;
    int miscompares, comparisons;
    rcocc_ctrl rcocc_ctrl_i (
        .ref_clk(ref_clk),
        .reset(reset),
        .ctrlWrite(ctrlWrite),
        .ctrlWriteData(ctrlWriteData),
        .oscModeWrite(oscModeWrite),
        .oscModeWriteData(oscModeWriteData),
        .decadeLoad(decadeLoad),
        .decadeLoadData(decadeLoadData),
        .binaryLoad(binaryLoad),
        .binaryLoadData(binaryLoadData),
        .rcOscClock(rcOscClock),
        .conversionEnable(conversionEnable),
        .counterRefSelect(counterRefSelect),
        .countRun(countRun),
        .converterIrq(converterIrq),
        .oscModeField(oscModeField),
        .oscPathEnable(oscPathEnable),
        .counts(counts)
    );
    rcocc_osc_model rcocc_osc_model_i (.pathEnable(oscPathEnable), .rc_osc_clock(rcOscClock));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run;
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [19:0] got, input logic [19:0] lo, input logic [19:0] hi);
        comparisons++;
        if (got >= lo && got <= hi) begin
        end else begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask
    // k: 0 control, 1 mode, 2 decade preset, 3 binary preset
    task automatic put(input int k, input logic [19:0] v);
        @(negedge ref_clk);
        {ctrlWrite, oscModeWrite, decadeLoad, binaryLoad} = 4'h8 >> k;
        ctrlWriteData = v[1:0];
        oscModeWriteData = v[3:0];
        decadeLoadData = v;
        binaryLoadData = v[13:0];
        @(negedge ref_clk);
        {ctrlWrite, oscModeWrite, decadeLoad, binaryLoad} = 4'h0;
    endtask
    task automatic conv(input logic [19:0] m, d, b, c);
        int n;
        put(1, m);
        put(2, d);
        put(3, b);
        put(0, c);
        n = 0;
        while (converterIrq !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
            if (n > 4000) begin
                miscompares++;
                complete_run();
            end
        end
        chk(20'(conversionEnable), 20'h0, 20'h0);
        chk(20'({countRun, counterRefSelect}), 20'(c[1]), 20'(c[1]));
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, ctrlWrite, oscModeWrite, decadeLoad, binaryLoad} = 5'h10;
        {ctrlWriteData, oscModeWriteData, decadeLoadData, binaryLoadData} = '0;
        repeat (8) @(negedge ref_clk);
        reset = 1'b0;
        conv(20'h1, 20'h79680, 20'h0, 20'h1);
        chk(20'(counts.binaryValue), 20'h13, 20'h15);
        repeat (30) @(negedge ref_clk);
        chk(20'(counts.binaryValue), 20'h13, 20'h15);
        $display("test decade_ref done");
        conv(20'h2, 20'h0, 20'h3FF6, 20'h3);
        chk(counts.decadeValue, 20'h140, 20'h165);
        repeat (30) @(negedge ref_clk);
        chk(counts.decadeValue, 20'h140, 20'h165);
        $display("test binary_ref done");
        conv(20'h1, 20'h0, 20'h3FF6, 20'h3);
        chk(counts.decadeValue, 20'h140, 20'h165);
        conv(20'h2, 20'h79680, 20'h0, 20'h1);
        chk(20'(counts.binaryValue), 20'h13, 20'h15);
        $display("test ratio_pair done");
        for (int m = 0; m < 9; m++) begin
            put(1, 20'(m));
            put(0, 20'h1);
            repeat (4) @(negedge ref_clk);
            chk(20'({countRun, counterRefSelect}), 20'h2, 20'h2);
            chk(20'(oscModeField), 20'(m), 20'(m));
            chk(20'(oscPathEnable), (m inside {[1:6]}) ? 20'h1 << m : 20'h0,
                (m inside {[1:6]}) ? 20'h1 << m : 20'h0);
            put(0, 20'h0);
            @(negedge ref_clk);
            chk(20'({oscPathEnable, converterIrq}), 20'h0, 20'h0);
            chk(20'(countRun), 20'h0, 20'h0);
        end
        $display("test mode_abort done");
        complete_run();
    end
endmodule // rcocc_ctrl_tb
`default_nettype wire
